/* tbpc_defs.svh */
// Constants of the two-channel buffered PWM timer: offsets, bit positions,
// reset values. Assumes a 32-bit register slave with byte addresses.
//
// Summary of operation
// - Link bit pairs channels onto pin zero
// - Channel zero first; channel one next period
// - Each wrap selects last written compare pair
// - Linked: zero control governs, pin one free
// - Level 1:0 clears, 1:1 sets on compare
// - No wrap toggle gives zero duty at level 1:0, full duty at 1:1
// - Full duty plus wrap toggle holds 100% at level 1:0, 0% at 0:1 and 1:1
// - Wrap flag at period; enable gates request
// - Channel flag on event; enable gates request
// - Wait: timer runs, registers closed, wake
// - Stop: count and compares frozen, captures still taken, resumes
// - Break freezes the counter
// - Clear allowed in break stays cleared
// - Clear locked in break; step two after
// - Pins capture or compare; only zero buffers
// - Flag clears by read-set then write zero
// - Divide by 1 to 64; code seven idle
`ifndef TBPC_DEFS_SVH
`define TBPC_DEFS_SVH

`define TBPC_IDX_CTRL     3'h0
`define TBPC_IDX_COUNT    3'h1
`define TBPC_IDX_PERIOD   3'h2
`define TBPC_IDX_C0_CTRL  3'h3
`define TBPC_IDX_C0_CMP   3'h4
`define TBPC_IDX_C1_CTRL  3'h5
`define TBPC_IDX_C1_CMP   3'h6
`define TBPC_IDX_STATUS   3'h7

`define TBPC_BIT_WRAP_FLAG  7
`define TBPC_BIT_WRAP_IE    6
`define TBPC_BIT_HALT       5
`define TBPC_BIT_CLR        4

`define TBPC_RST_PERIOD     16'hffff
`define TBPC_RST_HALT       1'b1
`define TBPC_SEL_NONE       3'h7

`endif

/* tbpc_pkg.sv */
// Types of the buffered PWM timer.
// Assumes tbpc_defs.svh for numeric constants.
package tbpc_pkg;

    typedef struct packed {
        logic       channel_event_flag;
        logic       channel_irq_enable;
        logic       buffered_mode_select;
        logic       unbuffered_mode_select;
        logic       edge_level_high_sel;
        logic       edge_level_low_sel;
        logic       toggle_on_wrap;
        logic       full_duty_force;
    } tbpc_chan_ctrl_t;

    typedef struct packed {
        logic [1:0] out;
        logic [1:0] oe;
    } tbpc_pins_t;

endpackage

/* tbpc_prescale.sv */
// Counter clock divider: one-cycle enable at bus clock / 2^sel.
// Assumes sel is held stable while counting.
`timescale 1ns/1ps
`default_nettype none
`include "tbpc_defs.svh"
module tbpc_prescale (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       clr,
    input  wire logic       run,
    input  wire logic [2:0] sel,
    output logic            tick_ff
);
    logic [5:0] div_ff;
    logic [5:0] nxt_div;
    logic [5:0] mask;
    logic       nxt_tick;

    always_comb begin
        mask     = 6'(7'h7f >> (3'h7 - sel)) ;
        nxt_div  = div_ff;
        nxt_tick = 1'b0;
        if (clr) begin
            nxt_div = 6'h00;
        end else if (run) begin
            nxt_div  = div_ff + 6'h01;
            // Code seven never ticks
            nxt_tick = (sel != `TBPC_SEL_NONE) && ((div_ff & mask) == mask);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            div_ff  <= 6'h00;
            tick_ff <= 1'b0;
        end else begin
            div_ff  <= nxt_div;
            tick_ff <= nxt_tick;
        end
    end
endmodule
`default_nettype wire

/* tbpc_pinsync.sv */
// Three-stage pin synchroniser; a level counts once stages two and three agree.
// Assumes asynchronous pin inputs.
`timescale 1ns/1ps
`default_nettype none
module tbpc_pinsync (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic [1:0] pin_in,
    output logic      [1:0] level_ff
);
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_bit
            logic s1_ff, s2_ff, s3_ff;
            logic nxt_level;
            always_comb begin
                nxt_level = (s2_ff == s3_ff) ? s3_ff : level_ff[g];
            end
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    s1_ff       <= 1'b0;
                    s2_ff       <= 1'b0;
                    s3_ff       <= 1'b0;
                    level_ff[g] <= 1'b0;
                end else begin
                    s1_ff       <= pin_in[g];
                    s2_ff       <= s1_ff;
                    s3_ff       <= s2_ff;
                    level_ff[g] <= nxt_level;
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

/* tbpc_top.sv */
// Two-channel timer with buffered PWM, capture, compare and wrap flags.
// Assumes an Avalon-MM master, low-power and break levels from the system,
// and port logic that owns the pin when the output enable is low.
`timescale 1ns/1ps
`default_nettype none
`include "tbpc_defs.svh"
module tbpc_top
    import tbpc_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        wait_mode,
    input  wire logic        stop_mode,
    input  wire logic        break_state,
    input  wire logic        break_clear_allow,
    input  wire logic [1:0]  chan_pin_in,
    output logic      [1:0]  chan_pin_out,
    output logic      [1:0]  chan_pin_oe,
    output logic             wrap_irq,
    output logic      [1:0]  chan_irq,
    output logic             wake_req
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    logic                  wait_ff;
    logic [31:0]           rdata_ff;
    logic                  wrap_flag_ff;
    logic                  wrap_irq_enable_ff;
    logic                  counter_halt_ff;
    logic [2:0]            clock_divide_sel_ff;
    logic                  wrap_arm_ff;
    logic [15:0]           cnt_ff;
    logic [15:0]           period_ff;
    tbpc_chan_ctrl_t [1:0] ctrl_ff;
    logic [1:0][15:0]      cmp_ff;
    logic [1:0]            arm_ff;
    logic                  active_ff;
    logic                  last_ff;
    logic [1:0]            prev_ff;
    tbpc_pins_t            pins_ff;
    logic                  wrap_irq_ff;
    logic [1:0]            chan_irq_ff;
    logic                  wake_ff;

    logic                  nxt_wait;
    logic [31:0]           nxt_rdata;
    logic                  nxt_wrap_flag;
    logic                  nxt_wrap_irq_enable;
    logic                  nxt_counter_halt;
    logic [2:0]            nxt_clock_divide_sel;
    logic                  nxt_wrap_arm;
    logic [15:0]           nxt_cnt;
    logic [15:0]           nxt_period;
    tbpc_chan_ctrl_t [1:0] nxt_ctrl;
    logic [1:0][15:0]      nxt_cmp;
    logic [1:0]            nxt_arm;
    logic                  nxt_active;
    logic                  nxt_last;
    tbpc_pins_t            nxt_pins;
    logic                  nxt_wrap_irq;
    logic [1:0]            nxt_chan_irq;
    logic                  nxt_wake;

    logic                  take;
    logic                  wr;
    logic                  rd;
    logic [2:0]            idx;
    logic [31:0]           wd;
    logic                  run;
    logic                  tick;
    logic                  presc_tick;
    logic                  cnt_clr;
    logic                  lock;
    logic                  link;
    logic                  wrap_hit;
    logic [1:0]            pin_lvl;
    logic [1:0]            oc;
    logic [1:0]            cap;
    logic [1:0]            hit;
    logic [1:0]            evt;
    logic [1:0]            edge_ok;
    logic [1:0]            dead;
    logic [15:0]           eff_cmp;
    logic                  o;

    // Byte-lane merge for partial writes
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    tbpc_prescale u_prescale (
        .sys_clk (sys_clk),
        .rst     (rst),
        .clr     (cnt_clr),
        .run     (run),
        .sel     (clock_divide_sel_ff),
        .tick_ff (presc_tick)
    );

    tbpc_pinsync u_pinsync (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .pin_in   (chan_pin_in),
        .level_ff (pin_lvl)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave: one wait cycle, then the request is taken

    always_comb begin
        take = (avs_read || avs_write) && !wait_ff;
        // Registers closed to the processor in wait mode
        wr   = take && avs_write && !wait_mode;
        rd   = take && avs_read && !wait_mode;
        idx  = avs_address[4:2];
        nxt_wait  = !((avs_read || avs_write) && wait_ff);
        nxt_rdata = rdata_ff;
        if ((avs_read || avs_write) && wait_ff) begin
            nxt_rdata = 32'h0000_0000;
            if (!wait_mode && avs_read) begin
                case (idx)
                    `TBPC_IDX_CTRL: begin
                        nxt_rdata = {24'h00_0000, wrap_flag_ff, wrap_irq_enable_ff,
                                     counter_halt_ff, 2'h0, clock_divide_sel_ff};
                    end
                    `TBPC_IDX_COUNT:   nxt_rdata = {16'h0000, cnt_ff};
                    `TBPC_IDX_PERIOD:  nxt_rdata = {16'h0000, period_ff};
                    `TBPC_IDX_C0_CTRL: nxt_rdata = {24'h00_0000, ctrl_ff[0]};
                    `TBPC_IDX_C0_CMP:  nxt_rdata = {16'h0000, cmp_ff[0]};
                    // Unused while linked
                    `TBPC_IDX_C1_CTRL: nxt_rdata = link ? 32'h0000_0000 : {24'h00_0000, ctrl_ff[1]};
                    `TBPC_IDX_C1_CMP:  nxt_rdata = {16'h0000, cmp_ff[1]};
                    `TBPC_IDX_STATUS:  nxt_rdata = {31'h0000_0000, active_ff};
                    default:           nxt_rdata = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wait_ff  <= 1'b1;
            rdata_ff <= 32'h0000_0000;
        end else begin
            wait_ff  <= nxt_wait;
            rdata_ff <= nxt_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Timer

    always_comb begin
        nxt_wrap_flag        = wrap_flag_ff;
        nxt_wrap_irq_enable  = wrap_irq_enable_ff;
        nxt_counter_halt     = counter_halt_ff;
        nxt_clock_divide_sel = clock_divide_sel_ff;
        nxt_wrap_arm         = wrap_arm_ff;
        nxt_cnt              = cnt_ff;
        nxt_period           = period_ff;
        nxt_ctrl             = ctrl_ff;
        nxt_cmp              = cmp_ff;
        nxt_arm              = arm_ff;
        nxt_active           = active_ff;
        nxt_last             = last_ff;
        nxt_pins             = pins_ff;
        oc                   = 2'b00;
        cap                  = 2'b00;
        hit                  = 2'b00;
        evt                  = 2'b00;
        edge_ok              = 2'b00;
        dead                 = 2'b00;
        eff_cmp              = cmp_ff[0];
        o                    = 1'b0;
        wd   = avs_writedata;
        link = ctrl_ff[0].buffered_mode_select;
        lock = break_state && !break_clear_allow;
        // Stop and break freeze the count; wait does not
        run  = !counter_halt_ff && !stop_mode && !break_state;
        tick = presc_tick && run;
        cnt_clr  = wr && (idx == `TBPC_IDX_CTRL) && avs_byteenable[0] && wd[`TBPC_BIT_CLR];
        wrap_hit = tick && (cnt_ff == period_ff);

        // Control and status register
        if (wr && idx == `TBPC_IDX_CTRL) begin
            wd = merge({24'h00_0000, wrap_flag_ff, wrap_irq_enable_ff, counter_halt_ff,
                        2'h0, clock_divide_sel_ff}, avs_writedata, avs_byteenable);
            nxt_wrap_irq_enable  = wd[`TBPC_BIT_WRAP_IE];
            nxt_counter_halt     = wd[`TBPC_BIT_HALT];
            nxt_clock_divide_sel = wd[2:0];
            // Second step of the clear; writing one does nothing
            if (!lock && wrap_arm_ff && !wd[`TBPC_BIT_WRAP_FLAG]) begin
                nxt_wrap_flag = 1'b0;
                nxt_wrap_arm  = 1'b0;
            end
        end
        // First step kept across break when locked
        if (rd && idx == `TBPC_IDX_CTRL && wrap_flag_ff && !lock) begin
            nxt_wrap_arm = 1'b1;
        end

        // Counter
        if (cnt_clr) begin
            nxt_cnt = 16'h0000;
        end else if (tick) begin
            nxt_cnt = wrap_hit ? 16'h0000 : cnt_ff + 16'h0001;
        end
        // Set wins over clear; a fresh wrap voids a pending clear
        if (wrap_hit) begin
            nxt_wrap_flag = 1'b1;
            nxt_wrap_arm  = 1'b0;
        end

        if (wr && idx == `TBPC_IDX_PERIOD) begin
            wd         = merge({16'h0000, period_ff}, avs_writedata, avs_byteenable);
            nxt_period = wd[15:0];
        end

        // Active pair follows the last written at each wrap
        if (!link) begin
            nxt_active = 1'b0;
        end else if (wrap_hit) begin
            nxt_active = last_ff;
        end

        for (int i = 0; i < 2; i++) begin
            // Channel one released to general I/O while linked
            dead[i] = (i == 1) && link;
            oc[i]   = !dead[i] && (ctrl_ff[i].unbuffered_mode_select || (i == 0 && link)) &&
                      (ctrl_ff[i].edge_level_high_sel || ctrl_ff[i].edge_level_low_sel);
            cap[i]  = !dead[i] && !ctrl_ff[i].unbuffered_mode_select && !(i == 0 && link) &&
                      (ctrl_ff[i].edge_level_high_sel || ctrl_ff[i].edge_level_low_sel);
            eff_cmp = (i == 0 && link && active_ff) ? cmp_ff[1] : cmp_ff[i];
            hit[i]  = oc[i] && tick && (cnt_ff == eff_cmp);
            edge_ok[i] = (pin_lvl[i] && !prev_ff[i] && ctrl_ff[i].edge_level_low_sel) ||
                         (!pin_lvl[i] && prev_ff[i] && ctrl_ff[i].edge_level_high_sel);
            evt[i]  = hit[i] || (cap[i] && !counter_halt_ff && edge_ok[i]);

            // Channel control register; ignored while unused
            if (wr && !dead[i] && idx == ((i == 0) ? `TBPC_IDX_C0_CTRL : `TBPC_IDX_C1_CTRL)) begin
                wd = merge({24'h00_0000, ctrl_ff[i]}, avs_writedata, avs_byteenable);
                nxt_ctrl[i] = tbpc_chan_ctrl_t'(wd[7:0]);
                nxt_ctrl[i].channel_event_flag = ctrl_ff[i].channel_event_flag;
                // Buffered mode only on channel zero
                if (i == 1) begin
                    nxt_ctrl[i].buffered_mode_select = 1'b0;
                end
                if (!lock && arm_ff[i] && !wd[7]) begin
                    nxt_ctrl[i].channel_event_flag = 1'b0;
                    nxt_arm[i] = 1'b0;
                end
            end
            if (rd && !dead[i] && ctrl_ff[i].channel_event_flag && !lock &&
                idx == ((i == 0) ? `TBPC_IDX_C0_CTRL : `TBPC_IDX_C1_CTRL)) begin
                nxt_arm[i] = 1'b1;
            end

            // Compare registers; a write marks the pair as latest
            if (wr && idx == ((i == 0) ? `TBPC_IDX_C0_CMP : `TBPC_IDX_C1_CMP)) begin
                wd         = merge({16'h0000, cmp_ff[i]}, avs_writedata, avs_byteenable);
                nxt_cmp[i] = wd[15:0];
                nxt_last   = (i == 1);
            end
            if (cap[i] && !counter_halt_ff && edge_ok[i]) begin
                nxt_cmp[i] = cnt_ff;
            end
            if (evt[i]) begin
                nxt_ctrl[i].channel_event_flag = 1'b1;
                nxt_arm[i] = 1'b0;
            end

            // Output: wrap starts the pulse, compare ends it
            o = pins_ff.out[i];
            if (oc[i]) begin
                // Without the wrap toggle, compares at levels 1:0 and 1:1 repeat the idle level
                if (wrap_hit && ctrl_ff[i].toggle_on_wrap) begin
                    o = !o;
                end
                if (hit[i]) begin
                    case ({ctrl_ff[i].edge_level_high_sel, ctrl_ff[i].edge_level_low_sel})
                        2'b01:   o = !o;
                        2'b10:   o = 1'b0;
                        2'b11:   o = 1'b1;
                        default: o = o;
                    endcase
                end
                if (ctrl_ff[i].full_duty_force && ctrl_ff[i].toggle_on_wrap) begin
                    o = !ctrl_ff[i].edge_level_low_sel;
                end
            end
            nxt_pins.out[i] = o;
            nxt_pins.oe[i]  = oc[i];
        end

        nxt_wrap_irq = nxt_wrap_flag && nxt_wrap_irq_enable;
        nxt_chan_irq[0] = nxt_ctrl[0].channel_event_flag && nxt_ctrl[0].channel_irq_enable;
        nxt_chan_irq[1] = nxt_ctrl[1].channel_event_flag && nxt_ctrl[1].channel_irq_enable &&
                          !nxt_ctrl[0].buffered_mode_select;
        nxt_wake = wait_mode && (nxt_wrap_irq || (|nxt_chan_irq));
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wrap_flag_ff        <= 1'b0;
            wrap_irq_enable_ff  <= 1'b0;
            counter_halt_ff     <= `TBPC_RST_HALT;
            clock_divide_sel_ff <= 3'h0;
            wrap_arm_ff         <= 1'b0;
            cnt_ff              <= 16'h0000;
            period_ff           <= `TBPC_RST_PERIOD;
            ctrl_ff             <= '0;
            cmp_ff              <= '0;
            arm_ff              <= 2'b00;
            active_ff           <= 1'b0;
            last_ff             <= 1'b0;
            prev_ff             <= 2'b00;
            pins_ff             <= '0;
            wrap_irq_ff         <= 1'b0;
            chan_irq_ff         <= 2'b00;
            wake_ff             <= 1'b0;
        end else begin
            wrap_flag_ff        <= nxt_wrap_flag;
            wrap_irq_enable_ff  <= nxt_wrap_irq_enable;
            counter_halt_ff     <= nxt_counter_halt;
            clock_divide_sel_ff <= nxt_clock_divide_sel;
            wrap_arm_ff         <= nxt_wrap_arm;
            cnt_ff              <= nxt_cnt;
            period_ff           <= nxt_period;
            ctrl_ff             <= nxt_ctrl;
            cmp_ff              <= nxt_cmp;
            arm_ff              <= nxt_arm;
            active_ff           <= nxt_active;
            last_ff             <= nxt_last;
            prev_ff             <= pin_lvl;
            pins_ff             <= nxt_pins;
            wrap_irq_ff         <= nxt_wrap_irq;
            chan_irq_ff         <= nxt_chan_irq;
            wake_ff             <= nxt_wake;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign avs_readdata    = rdata_ff;
    assign avs_waitrequest = wait_ff;
    assign chan_pin_out    = pins_ff.out;
    assign chan_pin_oe     = pins_ff.oe;
    assign wrap_irq        = wrap_irq_ff;
    assign chan_irq        = chan_irq_ff;
    assign wake_req        = wake_ff;

endmodule
`default_nettype wire

/* tbpc_chk_sva.sv */
// Checker: bus handshake, low-power and reset behaviour at the timer ports.
// Assumes binding into tbpc_top; inputs carry its port names.
`timescale 1ns/1ps
`default_nettype none
module tbpc_chk (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        wait_mode,
    input wire logic        stop_mode,
    input wire logic        break_state,
    input wire logic [1:0]  chan_pin_out,
    input wire logic [1:0]  chan_pin_oe,
    input wire logic        wrap_irq,
    input wire logic [1:0]  chan_irq,
    input wire logic        wake_req
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire any_irq = wrap_irq || chan_irq != 2'b00;
    ////////////////////////////////////////
    chk_reset_quiet: assert property (
        $fell(rst) |-> avs_waitrequest && !wrap_irq && chan_irq == 2'b00 && chan_pin_oe == 2'b00)
        else $error("outputs busy after reset");
    chk_wait_pulse: assert property (
        !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    chk_bus_answer: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered");
    chk_wait_rdzero: assert property (
        wait_mode && $past(wait_mode) && $past(wait_mode, 2) && avs_read && !avs_waitrequest
            |-> avs_readdata == 32'h0)
        else $error("read in wait mode not zero");
    chk_wake_set: assert property (
        $past(wait_mode) && $past(any_irq) && any_irq |-> wake_req)
        else $error("no wake on request in wait");
    chk_wake_clear: assert property (
        !$past(wait_mode) |-> !wake_req)
        else $error("wake outside wait");
    // Three cycles of margin: a tick already launched may still move the pin
    chk_stop_hold: assert property (
        stop_mode && $past(stop_mode) && $past(stop_mode, 2) && $past(stop_mode, 3)
            && !$past(avs_write) && !$past(avs_write, 2) |-> $stable(chan_pin_out))
        else $error("pin moved in stop");
    chk_break_hold: assert property (
        break_state && $past(break_state) && $past(break_state, 2) && $past(break_state, 3)
            && !$past(avs_write) && !$past(avs_write, 2) |-> $stable(chan_pin_out))
        else $error("pin moved in break");
endmodule
bind tbpc_top tbpc_chk u_chk (.*);
`default_nettype wire

/* test_tbpc_top.sv */
// Bench of the buffered PWM timer: table of register cases, then PWM cases.
// Assumes tbpc_top with its checker bound; no far-side model.
`timescale 1ns/1ps
`default_nettype none
module test_tbpc_top;
    logic        sys_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic        wait_mode = 1'b0, stop_mode = 1'b0, break_state = 1'b0, break_clear_allow = 1'b0;
    logic [4:0]  avs_address = 5'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rdv, cnt;
    logic [1:0]  chan_pin_out, chan_pin_oe, chan_irq, pin_drv = 2'b00;
    logic        avs_waitrequest, wrap_irq, wake_req;
    int          err_total = 0, checks_done = 0, h1, h2, h3;
    logic [37:0] rows [16] = '{
        {1'b0, 5'h00, 32'h20}, {1'b0, 5'h08, 32'hffff}, {1'b0, 5'h04, 32'h0}, {1'b0, 5'h0c, 32'h0},
        {1'b0, 5'h1c, 32'h0}, {1'b1, 5'h00, 32'he0}, {1'b0, 5'h00, 32'h60}, {1'b1, 5'h14, 32'hff},
        {1'b0, 5'h14, 32'h5f}, {1'b1, 5'h0c, 32'h20}, {1'b0, 5'h14, 32'h0}, {1'b1, 5'h14, 32'h10},
        {1'b1, 5'h0c, 32'h0}, {1'b0, 5'h14, 32'h5f}, {1'b1, 5'h14, 32'h0}, {1'b1, 5'h00, 32'h20}};
    tbpc_top DUT (.sys_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .wait_mode, .stop_mode,
        .break_state, .break_clear_allow, .chan_pin_in(pin_drv), .chan_pin_out, .chan_pin_oe,
        .wrap_irq, .chan_irq, .wake_req);
    ////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Holds the request until the edge that sees waitrequest low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        // No cycle count assumed; only the watchdog ends a hang
        do begin
            @(posedge sys_clk);
        end while (avs_waitrequest !== 1'b0);
        rdv = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // Twenty cycles span two periods of ten, so the phase does not matter
    task automatic settle_count(output int h);
        h = 0;
        repeat (30) @(posedge sys_clk);
        repeat (20) begin
            @(posedge sys_clk);
            h += (chan_pin_out[0] === 1'b1);
        end
    endtask
    task automatic freeze_cmp;
        bus(1'b0, 5'h04, 32'h0);
        cnt = rdv;
        repeat (20) @(posedge sys_clk);
        bus(1'b0, 5'h04, 32'h0);
        check(rdv, cnt);
    endtask
    ////////////////////////////////////////
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        tally_and_finish();
    end
    initial begin
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            bus(rows[i][37], rows[i][36:32], rows[i][31:0]);
            if (!rows[i][37])
                check(rdv, rows[i][31:0]);
        end
        bus(1'b1, 5'h00, 32'h30);
        bus(1'b1, 5'h08, 32'h9);
        bus(1'b1, 5'h10, 32'h3);
        bus(1'b1, 5'h0c, 32'h1a);
        bus(1'b1, 5'h00, 32'h0);
        settle_count(h1);
        check({31'h0, chan_pin_oe[0]}, 32'h1);
        bus(1'b1, 5'h10, 32'h6);
        settle_count(h2);
        check(32'(h2 - h1), 32'h6);
        bus(1'b1, 5'h0c, 32'h1e);
        settle_count(h3);
        check(32'(h2 + h3), 32'd20);
        bus(1'b1, 5'h0c, 32'h18);
        settle_count(h3);
        check(32'(h3), 32'h0);
        bus(1'b1, 5'h0c, 32'h1b);
        settle_count(h3);
        check(32'(h3), 32'd20);
        bus(1'b1, 5'h0c, 32'h2a);
        bus(1'b1, 5'h18, 32'h3);
        settle_count(h3);
        check(32'(h3), 32'(h1));
        bus(1'b0, 5'h1c, 32'h0);
        check(rdv, 32'h1);
        bus(1'b1, 5'h10, 32'h6);
        repeat (30) @(posedge sys_clk);
        bus(1'b0, 5'h1c, 32'h0);
        check(rdv, 32'h0);
        check({27'h0, chan_pin_oe, wrap_irq, chan_irq}, 32'h8);
        bus(1'b1, 5'h0c, 32'h6a);
        bus(1'b1, 5'h00, 32'h40);
        repeat (30) @(posedge sys_clk);
        check({29'h0, wrap_irq, chan_irq}, 32'h5);
        wait_mode <= 1'b1;
        repeat (3) @(posedge sys_clk);
        check({31'h0, wake_req}, 32'h1);
        bus(1'b0, 5'h08, 32'h0);
        check(rdv, 32'h0);
        bus(1'b1, 5'h08, 32'h5);
        wait_mode <= 1'b0;
        bus(1'b0, 5'h08, 32'h0);
        check(rdv, 32'h9);
        stop_mode <= 1'b1;
        freeze_cmp();
        stop_mode <= 1'b0;
        repeat (4) @(posedge sys_clk);
        bus(1'b0, 5'h04, 32'h0);
        check({31'h0, rdv !== cnt}, 32'h1);
        break_state <= 1'b1;
        freeze_cmp();
        break_state <= 1'b0;
        bus(1'b1, 5'h00, 32'hc7);
        freeze_cmp();
        bus(1'b0, 5'h00, 32'h0);
        check(rdv, 32'hc7);
        break_state <= 1'b1;
        bus(1'b1, 5'h00, 32'h47);
        repeat (2) @(posedge sys_clk);
        check({31'h0, wrap_irq}, 32'h1);
        break_state <= 1'b0;
        bus(1'b1, 5'h00, 32'h47);
        repeat (2) @(posedge sys_clk);
        check({31'h0, wrap_irq}, 32'h0);
        bus(1'b1, 5'h00, 32'h40);
        repeat (30) @(posedge sys_clk);
        bus(1'b1, 5'h00, 32'hc7);
        break_clear_allow <= 1'b1;
        break_state <= 1'b1;
        bus(1'b0, 5'h00, 32'h0);
        check(rdv, 32'hc7);
        bus(1'b1, 5'h00, 32'h47);
        break_state <= 1'b0;
        repeat (30) @(posedge sys_clk);
        check({31'h0, wrap_irq}, 32'h0);
        // Capture on channel zero with the count frozen by code seven
        bus(1'b0, 5'h0c, 32'h0);
        check(rdv, 32'hea);
        bus(1'b1, 5'h0c, 32'h4);
        pin_drv <= 2'b01;
        repeat (8) @(posedge sys_clk);
        bus(1'b0, 5'h0c, 32'h0);
        check(rdv, 32'h84);
        bus(1'b0, 5'h04, 32'h0);
        cnt = rdv;
        bus(1'b0, 5'h10, 32'h0);
        check(rdv, cnt);
        tally_and_finish();
    end
endmodule
`default_nettype wire
